/* rtl/exec_pkg.sv */
// Functional notes
// RL1: add-with-carry stores dst + src + carry into dst and leaves src alone.
// RL2: add-with-carry sets carry on carry out of bit 7, zero and sign per result.
// RL3: add-with-carry sets overflow when like-signed operands give other sign.
// RL4: add-with-carry clears the decimal flag and sets half carry from bit 3.
// RL5: add-with-carry takes 6 cycles for r/r and r/Ir, 10 for other forms.
// RL6: add-with-carry is opcodes 12h to 17h, 17h being indirect dst, immediate.
// RL7: operand byte Eh in the upper nibble selects a 4-bit working register.
// RL8: a call drops the stack pointer by 2, pushes the return address, jumps.
// RL9: call uses D6h with a direct address and D4h with a register pair, 20 cycles.
// RL10: a call keeps all six flags; a later return pops the address back.
// RL11: call pair byte with Eh upper nibble picks a working pair holding target.
// RL12: wide stack pointer in FEh/FFh pushes to data memory, narrow FFh to file.
// RL13: carry toggle, EFh, inverts carry in 6 cycles and keeps other flags.
// RL14: zero fill writes 00h in 6 cycles, B0h direct, B1h indirect, no flags.
// RL15: bit invert writes the one's complement in 6 cycles, 60h and 61h.
// RL16: bit invert sets zero and sign from result, clears overflow, keeps rest.
// RL17: indirect addressing reads a register and uses it as operand address.
package exec_pkg;
   // wishbone byte offsets; register file byte n sits at word n
   localparam logic [11:0] OFS_INSTR = 12'h400;
   localparam logic [11:0] OFS_STATUS = 12'h404;
   localparam logic [11:0] OFS_FLAGS = 12'h408;
   localparam logic [11:0] OFS_PC = 12'h40c;
   localparam logic [11:0] OFS_RP = 12'h410;
   localparam logic [11:0] OFS_CFG = 12'h414;
   // flag bit positions in the flags register
   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam int FLAG_D = 3;
   localparam int FLAG_H = 2;
   localparam logic [7:0] CCF_MASK = 8'h80;
   // reset values
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] RP_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;
   // opcodes
   localparam logic [7:0] OP_ADC_RR = 8'h12;
   localparam logic [7:0] OP_ADC_RIR = 8'h13;
   localparam logic [7:0] OP_ADC_R_R = 8'h14;
   localparam logic [7:0] OP_ADC_R_IR = 8'h15;
   localparam logic [7:0] OP_ADC_R_IM = 8'h16;
   localparam logic [7:0] OP_ADC_IR_IM = 8'h17;
   localparam logic [7:0] OP_CALL_DA = 8'hd6;
   localparam logic [7:0] OP_CALL_IRR = 8'hd4;
   localparam logic [7:0] OP_CCF = 8'hef;
   localparam logic [7:0] OP_CLR_R = 8'hb0;
   localparam logic [7:0] OP_CLR_IR = 8'hb1;
   localparam logic [7:0] OP_COM_R = 8'h60;
   localparam logic [7:0] OP_COM_IR = 8'h61;
   // working register marker and stack pointer registers
   localparam logic [3:0] WORK_NIB = 4'he;
   localparam logic [7:0] SP_HI_REG = 8'hfe;
   localparam logic [7:0] SP_LO_REG = 8'hff;
   // cycle counts and the steps inside a run
   localparam int CNT_W = 5;
   localparam logic [4:0] CYC_SHORT = 5'h06;
   localparam logic [4:0] CYC_LONG = 5'h0a;
   localparam logic [4:0] CYC_CALL = 5'h14;
   localparam logic [4:0] STEP_LATCH = 5'h04;
   localparam logic [4:0] STEP_PUSH_HI = 5'h03;
   localparam logic [4:0] STEP_PUSH_LO = 5'h02;
   localparam logic [4:0] STEP_COMMIT = 5'h01;
   // executor states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } exec_state_type;
endpackage

/* rtl/exec_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module exec_timer #(
   parameter int CW = 5
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // load request
   input wire logic load,
   input wire logic [CW-1:0] load_cycles,
   // progress
   output logic [CW-1:0] count,
   output logic busy
);
   // counts down to zero; busy stays high for exactly load_cycles cycles
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
         busy <= 1'b0;
      end else if (load) begin
         count <= load_cycles;
         busy <= 1'b1;
      end else if (count != '0) begin
         count <= count - 1'b1;
         busy <= (count > 1);
      end
   end
endmodule
`default_nettype wire

/* rtl/exec_alu.sv */
`timescale 1ns/100ps
`default_nettype none
module exec_alu (
   // operands
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   input wire logic sel_invert,
   // result and flags
   output logic [7:0] res,
   output logic carry,
   output logic zero,
   output logic sign,
   output logic ovf,
   output logic half
);
   logic [8:0] sum;
   logic [4:0] low_sum;

   // full byte and low nibble sums share the incoming carry
   assign sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
   assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
   // RL1 RL15 sum or complement
   assign res = sel_invert ? ~a : sum[7:0];
   assign carry = sum[8];
   assign half = low_sum[4];
   assign zero = (res == 8'h00);
   assign sign = res[7];
   // invert never overflows
   assign ovf = !sel_invert && (a[7] == b[7]) && (sum[7] != a[7]);
endmodule
`default_nettype wire

/* rtl/exec_core.sv */
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module exec_core (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // external data memory write port
   output logic ext_we,
   output logic [15:0] ext_addr,
   output logic [7:0] ext_wdata,
   // status
   output logic busy
);
   import exec_pkg::*;

   logic [7:0] rf [0:255];
   exec_state_type state;
   logic [7:0] opcode, byte1, byte2, flags, rp;
   logic [15:0] pc, call_sp, call_target, call_ret;
   logic stack_wide, bad_op;
   logic [CNT_W-1:0] count;

   // indirect or direct register address, with working register shorthand
   function automatic logic [7:0] reg_addr(input logic [7:0] b,
                                           input logic [7:0] ptr);
      reg_addr = (b[7:4] == WORK_NIB) ? {ptr[7:4], b[3:0]} : b;
   endfunction
   function automatic logic [7:0] work_addr(input logic [3:0] n,
                                            input logic [7:0] ptr);
      work_addr = {ptr[7:4], n};
   endfunction
   // instruction byte length, used for the return address and pc step
   function automatic logic [15:0] ins_len(input logic [7:0] op);
      if (op == OP_CCF)
         ins_len = 16'h0001;
      else if (op == OP_CALL_DA || (op >= OP_ADC_R_R && op <= OP_ADC_IR_IM))
         ins_len = 16'h0003;
      else
         ins_len = 16'h0002;
   endfunction
   // opcode classes
   function automatic logic [2:0] op_class(input logic [7:0] op);
      // 1 adc, 2 call, 3 ccf, 4 clr, 5 com, 0 unknown
      if (op >= OP_ADC_RR && op <= OP_ADC_IR_IM)
         op_class = 3'h1;
      else if (op == OP_CALL_DA || op == OP_CALL_IRR)
         op_class = 3'h2;
      else if (op == OP_CCF)
         op_class = 3'h3;
      else if (op == OP_CLR_R || op == OP_CLR_IR)
         op_class = 3'h4;
      else if (op == OP_COM_R || op == OP_COM_IR)
         op_class = 3'h5;
      else
         op_class = 3'h0;
   endfunction
   // RL5 RL9 cycle counts
   function automatic logic [4:0] op_cycles(input logic [7:0] op);
      if (op == OP_CALL_DA || op == OP_CALL_IRR)
         op_cycles = CYC_CALL;
      else if (op >= OP_ADC_R_R && op <= OP_ADC_IR_IM)
         op_cycles = CYC_LONG;
      else
         op_cycles = CYC_SHORT;
   endfunction
   // bus decode
   logic [11:0] wadr;
   logic in_rf, bus_req, wb_wr, idle, start, new_bad;
   logic [7:0] rf_idx;
   logic [31:0] rd_word;
   assign wadr = {wb_adr_i[11:2], 2'b00};
   assign in_rf = (wb_adr_i[11:10] == 2'b00);
   assign rf_idx = wb_adr_i[9:2];
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign wb_wr = bus_req && wb_we_i && wb_ack_o;
   assign idle = (state == ST_IDLE);
   // instruction writes need all three low lanes; busy refuses them
   assign start = wb_wr && idle && wadr == OFS_INSTR && (&wb_sel_i[2:0])
                  && op_class(wb_dat_i[7:0]) != 3'h0;
   assign new_bad = wb_wr && idle && wadr == OFS_INSTR && (&wb_sel_i[2:0])
                    && op_class(wb_dat_i[7:0]) == 3'h0;
   // read mux; unmapped words read zero
   assign rd_word = in_rf ? {24'h000000, rf[rf_idx]} :
      (wadr == OFS_INSTR) ? {8'h00, byte2, byte1, opcode} :
      (wadr == OFS_STATUS) ? {30'h00000000, bad_op, busy} :
      (wadr == OFS_FLAGS) ? {24'h000000, flags} :
      (wadr == OFS_PC) ? {16'h0000, pc} :
      (wadr == OFS_RP) ? {24'h000000, rp} :
      (wadr == OFS_CFG) ? {31'h00000000, stack_wide} : 32'h00000000;
   // one cycle answer; ack drops the cycle after it was given
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req && !wb_ack_o;
         wb_dat_o <= (bus_req && !wb_ack_o) ? rd_word : 32'h00000000;
      end
   end
   exec_timer #(.CW(CNT_W)) u_timer (
      .clk(clk),
      .resetn(resetn),
      .load(start),
      .load_cycles(op_cycles(wb_dat_i[7:0])),
      .count(count),
      .busy(busy)
   );
   // decode of the latched instruction
   logic is_adc, is_call, is_ccf, is_clr, is_com, running, commit;
   assign is_adc = (op_class(opcode) == 3'h1);
   assign is_call = (op_class(opcode) == 3'h2);
   assign is_ccf = (op_class(opcode) == 3'h3);
   assign is_clr = (op_class(opcode) == 3'h4);
   assign is_com = (op_class(opcode) == 3'h5);
   assign running = (state == ST_RUN);
   assign commit = running && count == STEP_COMMIT;
   // operand addressing
   logic [7:0] w_hi, w_lo, r1, r2, src_ind, dst_addr, src_val, dst_val;
   // RL7 working register shorthand
   assign w_hi = work_addr(byte1[7:4], rp);
   assign w_lo = work_addr(byte1[3:0], rp);
   assign r1 = reg_addr(byte1, rp);
   assign r2 = reg_addr(byte2, rp);
   // RL17 indirect operand fetch
   assign src_ind = (opcode == OP_ADC_RIR) ? rf[w_lo] : rf[r1];
   // RL6 operand placement per adc form
   assign dst_addr =
      (opcode == OP_ADC_RR || opcode == OP_ADC_RIR) ? w_hi :
      (opcode == OP_ADC_R_R || opcode == OP_ADC_R_IR) ? r2 :
      (opcode == OP_ADC_IR_IM || opcode == OP_CLR_IR
       || opcode == OP_COM_IR) ? rf[r1] : r1;
   assign src_val = (opcode == OP_ADC_RR) ? rf[w_lo] :
      (opcode == OP_ADC_R_R) ? rf[r1] :
      (opcode == OP_ADC_RIR || opcode == OP_ADC_R_IR) ? rf[src_ind] : byte2;
   assign dst_val = rf[dst_addr];
   // arithmetic
   logic [7:0] alu_res, result;
   logic alu_c, alu_z, alu_s, alu_v, alu_h;
   exec_alu u_alu (
      .a(dst_val),
      .b(src_val),
      .cin(flags[FLAG_C]),
      .sel_invert(is_com),
      .res(alu_res),
      .carry(alu_c),
      .zero(alu_z),
      .sign(alu_s),
      .ovf(alu_v),
      .half(alu_h)
   );
   // RL14 zero fill result
   assign result = is_clr ? 8'h00 : alu_res;
   // flag update per instruction; untouched bits pass through
   logic [7:0] next_flags;
   always_comb begin
      next_flags = flags;
      if (is_adc) begin
         // RL2 RL3 RL4 adc flags
         next_flags[FLAG_C] = alu_c;
         next_flags[FLAG_Z] = alu_z;
         next_flags[FLAG_S] = alu_s;
         next_flags[FLAG_V] = alu_v;
         next_flags[FLAG_D] = 1'b0;
         next_flags[FLAG_H] = alu_h;
      end else if (is_com) begin
         // RL16 invert flags
         next_flags[FLAG_Z] = alu_z;
         next_flags[FLAG_S] = alu_s;
         next_flags[FLAG_V] = 1'b0;
      end else if (is_ccf) begin
         // RL13 carry toggle
         next_flags[FLAG_C] = !flags[FLAG_C];
      end
   end
   // stack and call target
   logic [15:0] sp_now, pair_target;
   logic [7:0] pair_addr;
   logic push_hi, push_lo, push_int_hi, push_int_lo;
   // RL12 wide pointer spans FEh/FFh, narrow uses FFh only
   assign sp_now = stack_wide ? {rf[SP_HI_REG], rf[SP_LO_REG]}
                              : {8'h00, rf[SP_LO_REG]};
   // RL11 register pair holding the target
   assign pair_addr = reg_addr(byte1, rp);
   assign pair_target = {rf[pair_addr], rf[pair_addr + 8'h01]};
   assign push_hi = running && is_call && count == STEP_PUSH_HI;
   assign push_lo = running && is_call && count == STEP_PUSH_LO;
   assign push_int_hi = push_hi && !stack_wide;
   assign push_int_lo = push_lo && !stack_wide;

   // register file write ports: bus, execution, stack pointer high byte
   logic rf_wb_we, we0, we1;
   logic [7:0] wa0, wd0;
   assign rf_wb_we = wb_wr && idle && in_rf && wb_sel_i[0];
   assign we0 = push_int_hi || push_int_lo
                || (commit && (is_adc || is_clr || is_com || is_call));
   // RL8 narrow push lands in the register file, high byte first
   assign wa0 = push_int_hi ? call_sp[7:0] :
                push_int_lo ? call_sp[7:0] + 8'h01 :
                is_call ? SP_LO_REG : dst_addr;
   assign wd0 = push_int_hi ? call_ret[15:8] :
                push_int_lo ? call_ret[7:0] :
                is_call ? call_sp[7:0] : result;
   assign we1 = commit && is_call && stack_wide;
   // register file storage carries no reset; it is data, not control
   always_ff @(posedge clk) begin
      if (rf_wb_we)
         rf[rf_idx] <= wb_dat_i[7:0];
      if (we0)
         rf[wa0] <= wd0;
      if (we1)
         rf[SP_HI_REG] <= call_sp[15:8];
   end

   // executor state, latched instruction and bad opcode status
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         opcode <= 8'h00;
         byte1 <= 8'h00;
         byte2 <= 8'h00;
         bad_op <= 1'b0;
      end else begin
         if (start) begin
            state <= ST_RUN;
            opcode <= wb_dat_i[7:0];
            byte1 <= wb_dat_i[15:8];
            byte2 <= wb_dat_i[23:16];
         end else if (commit) begin
            state <= ST_IDLE;
         end
         if (start || new_bad)
            bad_op <= new_bad;
      end
   end

   // RL8 RL9 call values are caught before the pushes can disturb them
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         call_sp <= 16'h0000;
         call_target <= 16'h0000;
         call_ret <= 16'h0000;
      end else if (running && is_call && count == STEP_LATCH) begin
         call_sp <= stack_wide ? sp_now - 16'h0002
                               : {8'h00, sp_now[7:0] - 8'h02};
         call_target <= (opcode == OP_CALL_DA) ? {byte1, byte2} : pair_target;
         call_ret <= pc + ins_len(opcode);
      end
   end

   // RL12 wide stack pushes go to external data memory, big endian
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ext_we <= 1'b0;
         ext_addr <= 16'h0000;
         ext_wdata <= 8'h00;
      end else begin
         ext_we <= stack_wide && (push_hi || push_lo);
         ext_addr <= push_hi ? call_sp : call_sp + 16'h0001;
         ext_wdata <= push_hi ? call_ret[15:8] : call_ret[7:0];
      end
   end

   // software-owned state; bus writes are refused while a run is active
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flags <= FLAGS_RST;
         pc <= PC_RST;
         rp <= RP_RST;
         stack_wide <= 1'b0;
      end else if (commit) begin
         // RL10 a call leaves flags alone and jumps
         flags <= next_flags;
         pc <= is_call ? call_target : pc + ins_len(opcode);
      end else if (wb_wr && idle) begin
         if (wadr == OFS_FLAGS && wb_sel_i[0])
            flags <= wb_dat_i[7:0];
         if (wadr == OFS_PC && wb_sel_i[0])
            pc[7:0] <= wb_dat_i[7:0];
         if (wadr == OFS_PC && wb_sel_i[1])
            pc[15:8] <= wb_dat_i[15:8];
         if (wadr == OFS_RP && wb_sel_i[0])
            rp <= wb_dat_i[7:0];
         if (wadr == OFS_CFG && wb_sel_i[0])
            stack_wide <= wb_dat_i[0];
      end
   end
   // checking helpers: run length and an independent adc reference
   logic [4:0] run_len, exp_len, ref_low;
   logic [8:0] ref_full;
   logic [7:0] ref_sum;
   logic ref_carry, ref_ovf, ref_half;
   assign ref_full = {1'b0, dst_val} + {1'b0, src_val}
                     + {8'h00, flags[FLAG_C]};
   assign ref_low = {1'b0, dst_val[3:0]} + {1'b0, src_val[3:0]}
                    + {4'h0, flags[FLAG_C]};
   assign ref_sum = ref_full[7:0];
   assign ref_carry = ref_full[8];
   assign ref_half = ref_low[4];
   assign ref_ovf = (dst_val[7] == src_val[7]) && (ref_sum[7] != dst_val[7]);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         run_len <= 5'h00;
         exp_len <= 5'h00;
      end else if (start) begin
         run_len <= 5'h00;
         exp_len <= op_cycles(wb_dat_i[7:0]);
      end else if (busy) begin
         run_len <= run_len + 5'h01;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_adc_sum_store: assert property ( // RL1
      commit && is_adc |=> rf[$past(dst_addr)] == $past(ref_sum))
      else $error("adc stored a wrong sum");
   a_adc_carry_zero: assert property ( // RL2
      commit && is_adc |=> flags[FLAG_C] == $past(ref_carry)
         && flags[FLAG_Z] == ($past(ref_sum) == 8'h00))
      else $error("adc carry or zero flag wrong");
   a_adc_overflow: assert property ( // RL3
      commit && is_adc |=> flags[FLAG_V] == $past(ref_ovf))
      else $error("adc overflow flag wrong");
   a_adc_dec_half: assert property ( // RL4
      commit && is_adc |=> !flags[FLAG_D] && flags[FLAG_H] == $past(ref_half))
      else $error("adc decimal or half carry flag wrong");
   a_run_length: assert property ( // RL5
      $fell(busy) |-> run_len == exp_len)
      else $error("instruction took the wrong number of cycles");
   a_call_stack_jump: assert property ( // RL8
      commit && is_call |=> sp_now == $past(call_sp)
         && pc == $past(call_target))
      else $error("call stack pointer or target wrong");
   a_call_flags_kept: assert property ( // RL10
      commit && is_call |=> $stable(flags))
      else $error("call changed a flag");
   a_carry_toggle: assert property ( // RL13
      commit && is_ccf |=> flags == ($past(flags) ^ CCF_MASK))
      else $error("carry toggle wrong");
   a_fill_zero: assert property ( // RL14
      commit && is_clr |=> rf[$past(dst_addr)] == 8'h00 && $stable(flags))
      else $error("zero fill wrong");
   a_invert_flags: assert property ( // RL16
      commit && is_com |=> !flags[FLAG_V]
         && flags[FLAG_S] == rf[$past(dst_addr)][7]
         && flags[FLAG_C] == $past(flags[FLAG_C]))
      else $error("invert flags wrong");
   c_adc_carry: cover property (commit && is_adc && ref_carry);
   c_call_wide: cover property (commit && is_call && stack_wide);
   c_call_narrow: cover property (commit && is_call && !stack_wide);
   c_invert_zero: cover property (commit && is_com && alu_z);
endmodule
`default_nettype wire

/* verification/cpu_adc_call_clear_compl_exec_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module cpu_adc_call_clear_compl_exec_bench;
   import exec_pkg::*;
   typedef struct {string name; logic [31:0] exp;} note_type;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, ext_we, busy;
   logic [15:0] ext_addr;
   logic [7:0] ext_wdata;
   note_type notes[$];
   int fails = 0, checks_done = 0, ticks = 0, bcnt = 0;
   int seed;
   logic [7:0] a, b, d;
   logic c;

   exec_core exec_core_inst (
      .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .ext_we(ext_we),
      .ext_addr(ext_addr), .ext_wdata(ext_wdata), .busy(busy));

   always #4 clk = ~clk;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic take(input logic [31:0] seen);
      note_type n;
      if (notes.size() == 0) begin
         n = '{"unexpected", 32'hx};
      end else begin
         n = notes.pop_front();
      end
      check(n.name, seen, n.exp);
   endtask

   // watcher: read data, stack pushes to memory and run lengths
   always @(posedge clk) begin
      ticks++;
      if (ticks == 30000) begin
         fails++;
         print_verdict();
      end
      if (ack === 1'b1 && we === 1'b0) take(rdat);
      if (ext_we === 1'b1) take({8'h00, ext_addr, ext_wdata});
      if (busy === 1'b1) bcnt++;
      else if (bcnt != 0) begin
         take(32'(bcnt));
         bcnt = 0;
      end
   end

   // one classic cycle, idle cycle first, released after the ack edge
   task automatic bus(input logic w, input logic [11:0] ad,
                      input logic [31:0] dt);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= dt;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 64);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         fails++;
         print_verdict();
      end
   endtask

   function automatic logic [11:0] ra(input logic [7:0] r);
      return {2'b00, r, 2'b00};
   endfunction

   task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
      bus(1'b1, ad, dt);
   endtask

   task automatic rd(input string nm, input logic [11:0] ad,
                     input logic [31:0] e);
      notes.push_back('{nm, e});
      bus(1'b0, ad, 32'h0);
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (busy !== 1'b0 && k < 64);
      // a run that never ends counts as a mismatch
      if (busy !== 1'b0) begin
         fails++;
         print_verdict();
      end
   endtask

   // issue one instruction and note how long busy must stand
   task automatic exec(input logic [23:0] w, input int n);
      notes.push_back('{"cycles", 32'(n)});
      wr(OFS_INSTR, {8'h00, w});
      wait_idle();
   endtask

   // reference flags for add with carry, low two bits left clear
   function automatic logic [7:0] adc_f(input logic [7:0] x, y,
                                        input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      return {s[8], s[7:0] == 8'h00, s[7], x[7] == y[7] && s[7] != x[7],
              1'b0, h[4], 2'b00};
   endfunction

   initial begin
      seed = 32'he353;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rd("flags", OFS_FLAGS, 32'h0);
      rd("pc", OFS_PC, 32'h0);
      rd("rp", OFS_RP, 32'h0);
      rd("cfg", OFS_CFG, 32'h0);
      rd("unmapped", 12'h418, 32'h0);
      $display("test reset done");
      wr(OFS_RP, 32'h10);
      wr(OFS_PC, 32'h100);
      wr(ra(8'h13), 32'h16);
      wr(ra(8'h1b), 32'h20);
      wr(OFS_FLAGS, 32'h80);
      exec(24'h003b12, 6);
      rd("r3", ra(8'h13), 32'h37);
      rd("r11", ra(8'h1b), 32'h20);
      rd("flags", OFS_FLAGS, 32'h0);
      rd("pc", OFS_PC, 32'h102);
      wr(ra(8'h1f), 32'h16);
      wr(ra(8'h1a), 32'h20);
      wr(ra(8'h20), 32'h11);
      wr(OFS_FLAGS, 32'h0);
      exec(24'h00fa13, 6);
      rd("r15", ra(8'h1f), 32'h27);
      wr(ra(8'h34), 32'h2e);
      wr(ra(8'h12), 32'h1b);
      wr(OFS_FLAGS, 32'h80);
      exec(24'h341214, 10);
      rd("r34", ra(8'h34), 32'h4a);
      rd("flags", OFS_FLAGS, 32'h04);
      rd("pc", OFS_PC, 32'h107);
      wr(ra(8'h4b), 32'h82);
      wr(ra(8'h10), 32'h01);
      wr(ra(8'h13), 32'h10);
      wr(OFS_FLAGS, 32'h80);
      exec(24'h4be315, 10);
      rd("r4b", ra(8'h4b), 32'h84);
      rd("flags", OFS_FLAGS, 32'h20);
      wr(ra(8'hd4), 32'h5f);
      wr(ra(8'h5f), 32'h4c);
      wr(OFS_FLAGS, 32'h80);
      exec(24'h02d417, 10);
      rd("r5f", ra(8'h5f), 32'h4f);
      // random immediate adds sweep carry, overflow and half carry
      repeat (12) begin
         a = 8'($random(seed));
         b = 8'($random(seed));
         c = 1'($random(seed));
         d = 8'h40 + {4'h0, 4'($random(seed))};
         wr(ra(d), {24'h0, a});
         wr(OFS_FLAGS, {24'h0, c, 7'h00});
         exec({b, d, 8'h16}, 10);
         rd("sum", ra(d), {24'h0, a + b + {7'h00, c}});
         rd("flags", OFS_FLAGS, {24'h0, adc_f(a, b, c)});
      end
      $display("test add done");
      wr(OFS_CFG, 32'h1);
      wr(ra(8'hfe), 32'h30);
      wr(ra(8'hff), 32'h02);
      wr(OFS_PC, 32'h1a47);
      wr(OFS_FLAGS, 32'hfc);
      notes.push_back('{"push", 32'h0030001a});
      notes.push_back('{"push", 32'h0030014a});
      exec(24'h2135d6, 20);
      rd("sphi", ra(8'hfe), 32'h30);
      rd("splo", ra(8'hff), 32'h00);
      rd("pc", OFS_PC, 32'h3521);
      rd("flags", OFS_FLAGS, 32'hfc);
      wr(OFS_CFG, 32'h0);
      wr(ra(8'hff), 32'h72);
      wr(ra(8'h14), 32'h35);
      wr(ra(8'h15), 32'h21);
      wr(OFS_PC, 32'h1a47);
      exec(24'h00e4d4, 20);
      rd("r70", ra(8'h70), 32'h1a);
      rd("r71", ra(8'h71), 32'h49);
      rd("splo", ra(8'hff), 32'h70);
      rd("pc", OFS_PC, 32'h3521);
      rd("flags", OFS_FLAGS, 32'hfc);
      $display("test call done");
      wr(OFS_INSTR, 32'hff);
      rd("status", OFS_STATUS, 32'h2);
      wr(OFS_FLAGS, 32'h7c);
      exec(24'h0000ef, 6);
      rd("flags", OFS_FLAGS, 32'hfc);
      rd("status", OFS_STATUS, 32'h0);
      exec(24'h0000ef, 6);
      rd("flags", OFS_FLAGS, 32'h7c);
      rd("pc", OFS_PC, 32'h3523);
      wr(OFS_FLAGS, 32'hfc);
      wr(ra(8'h16), 32'haf);
      exec(24'h00e6b0, 6);
      rd("r16", ra(8'h16), 32'h0);
      wr(ra(8'ha5), 32'h23);
      wr(ra(8'h23), 32'hfc);
      exec(24'h00a5b1, 6);
      rd("r23", ra(8'h23), 32'h0);
      rd("flags", OFS_FLAGS, 32'hfc);
      wr(OFS_FLAGS, 32'h9c);
      wr(ra(8'h08), 32'h24);
      exec(24'h000860, 6);
      rd("r08", ra(8'h08), 32'hdb);
      rd("flags", OFS_FLAGS, 32'hac);
      wr(ra(8'h08), 32'h24);
      wr(ra(8'h24), 32'hff);
      wr(OFS_FLAGS, 32'h9c);
      exec(24'h000861, 6);
      rd("r24", ra(8'h24), 32'h0);
      rd("flags", OFS_FLAGS, 32'hcc);
      $display("test unary done");
      // writes landing mid-run must be dropped
      wr(ra(8'h60), 32'h11);
      notes.push_back('{"cycles", 32'd10});
      wr(OFS_INSTR, 32'h341214);
      wr(ra(8'h60), 32'h55);
      wr(OFS_INSTR, 32'h0000ef);
      wait_idle();
      rd("r60", ra(8'h60), 32'h11);
      rd("status", OFS_STATUS, 32'h0);
      $display("test busy done");
      repeat (4) @(posedge clk);
      if (notes.size() != 0) fails++;
      print_verdict();
   end
endmodule
`default_nettype wire
